//--- bench/bapr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bapr_ctl_model
  import bapr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         cmd_accept,
  output logic              cmd_activate,
  output logic              cmd_read,
  output logic              cmd_write,
  output logic              cmd_precharge,
  output logic              cmd_refresh,
  output logic              bank_select_low,
  output logic              bank_select_high,
  output logic              precharge_scope_line,
  output logic              burst_rd_done,
  output logic              burst_wr_done,
  output logic [BANK_W-1:0] burst_bank
);
  // quiet command bus until the first call
  initial
  begin
    {cmd_refresh, cmd_precharge, cmd_write, cmd_read, cmd_activate} = 5'h00;
    {bank_select_high, bank_select_low, precharge_scope_line} = 3'h0;
    {burst_wr_done, burst_rd_done} = 2'h0;
    burst_bank = 2'h0;
  end
  // one cycle of the bus, op 7 is a no-op; clock never stops here
  // callers leave a closing bank alone and send one refresh with a bank still open
  task automatic step(input logic [2:0] op, input logic [1:0] b,
    input logic sc, input logic [1:0] dn, output logic acc);
    @(negedge clk);
    {cmd_refresh, cmd_precharge, cmd_write, cmd_read, cmd_activate} =
      5'(5'h01 << op);
    {bank_select_high, bank_select_low} = b;
    precharge_scope_line = sc;
    {burst_wr_done, burst_rd_done} = dn;
    burst_bank = b;
    #1 acc = cmd_accept;
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bapr_pkg::*;
  localparam logic [2:0]  ACT = 3'h0, RD = 3'h1, WR = 3'h2, PRE = 3'h3;
  localparam logic [2:0]  REF = 3'h4, NOP = 3'h7;
  logic                   clk, nrst, cmd_activate, cmd_read, cmd_write;
  logic                   cmd_precharge, cmd_refresh, bank_select_low;
  logic                   bank_select_high, precharge_scope_line;
  logic                   burst_rd_done, burst_wr_done, cmd_accept;
  logic                   refresh_busy, refresh_fire;
  logic [BANK_W-1:0]      burst_bank;
  logic [2*NUM_BANKS-1:0] bank_phase;
  logic [NUM_BANKS-1:0]   precharge_start, row_time_met;
  logic [ROW_W-1:0]       refresh_row;
  int                     err_count, total_checks, seed, r, rb, fe;
  int                     ph[NUM_BANKS], rp[NUM_BANKS];
  int                     w[NUM_BANKS], ras[NUM_BANKS];
  int                     rq[$];

  bank_autoprecharge_refresh dut_u (
    .clk, .nrst, .cmd_activate, .cmd_read, .cmd_write, .cmd_precharge,
    .cmd_refresh, .bank_select_low, .bank_select_high,
    .precharge_scope_line, .burst_rd_done, .burst_wr_done, .burst_bank,
    .cmd_accept, .bank_phase, .precharge_start, .row_time_met,
    .refresh_busy, .refresh_fire, .refresh_row
  );
  bapr_ctl_model ctl_u (
    .clk, .cmd_accept, .cmd_activate, .cmd_read, .cmd_write,
    .cmd_precharge, .cmd_refresh, .bank_select_low, .bank_select_high,
    .precharge_scope_line, .burst_rd_done, .burst_wr_done, .burst_bank
  );

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] sv, ev);
    total_checks++;
    if (sv !== ev)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ev, sv);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one bus cycle: predict, drive, compare, then step the model over the
  // edge; phase 4 marks an explicit precharge, shown as 3 with no pulse
  task automatic go(input logic [2:0] op, input logic [1:0] b,
    input logic sc, input logic [1:0] dn);
    logic        a, e;
    int          nopen, nidle;
    logic [15:0] ev, sv, rv;
    nopen = 0;
    nidle = 0;
    ev = 16'h0000;
    sv = 16'h0000;
    rv = 16'h0000;
    foreach (ph[i])
    begin
      nopen += int'(ph[i] == 1);
      nidle += int'(ph[i] == 0);
      ev[2*i +: 2] = (ph[i] == 4) ? 2'h3 : 2'(ph[i]);
      sv[i] = ph[i] == 3 && rp[i] == RP_CYC;
      rv[i] = ras[i] == 0;
    end
    case (op)
      ACT: e = rb == 0 && ph[b] == 0;
      RD, WR: e = rb == 0 && ph[b] == 1;
      PRE: e = rb == 0 && (sc ? nopen > 0 : ph[b] == 1);
      REF: e = rb == 0 && nidle == NUM_BANKS;
      default: e = 1'b0;
    endcase
    ctl_u.step(op, b, sc, dn, a);
    chk("accept", 16'(a), 16'(e));
    chk("phase", 16'(bank_phase), ev);
    chk("start", 16'(precharge_start), sv);
    chk("row_met", 16'(row_time_met), rv);
    chk("busy", 16'(refresh_busy), 16'(rb > 0));
    chk("fire", 16'(refresh_fire), 16'(fe));
    // first refresh after reset takes row zero, then rows count up
    rv = (rq.size() > 0) ? 16'(rq[$] + 1) & 16'h1fff : 16'h0000;
    if (fe != 0)
      chk("row", 16'(refresh_row), rv);
    if (fe != 0)
      rq.push_back(int'(refresh_row));
    fe = 0;
    if (rb > 0)
      rb--;
    foreach (ph[i])
    begin
      if (dn != 2'h0 && b == i && ph[i] == 2)
        w[i] = dn[1] ? int'(WR_CYC) : 0;
      if (ph[i] >= 3)
        rp[i]--;
      if (ph[i] >= 3 && rp[i] == 0)
        ph[i] = 0;
      if (ph[i] == 2 && w[i] > 0)
        w[i]--;
      else if (ph[i] == 2 && w[i] == 0 && ras[i] == 0)
      begin
        ph[i] = 3;
        rp[i] = RP_CYC;
      end
      if (ras[i] > 0)
        ras[i]--;
    end
    if (e && op == ACT)
      ras[b] = RAS_CYC;
    if (e && (op == RD || op == WR))
      w[b] = -1;
    // refresh ignores the scope line, only bank commands move a bank
    if (e && (op == ACT || op == RD || op == WR))
      ph[b] = (op == ACT || sc) ? 1 + int'(op != ACT) : ph[b];
    if (e && op == REF)
      rb = RFC_CYC;
    fe = int'(e && op == REF);
    foreach (ph[i])
      if (e && op == PRE && ph[i] == 1 && (sc || b == i))
      begin
        ph[i] = 4;
        rp[i] = RP_CYC;
      end
  endtask

  task automatic nops(input int n);
    repeat (n) go(NOP, 2'h0, 1'b0, 2'h0);
  endtask

  // hang guard, far beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    close_out();
  end

  // main sequence; directed tests space row time before each explicit precharge, the random run does not
  initial
  begin
    err_count = 0;
    total_checks = 0;
    seed = 78898;
    rb = 0;
    fe = 0;
    foreach (ph[i])
    begin
      ph[i] = 0;
      rp[i] = 0;
      w[i] = -1;
      ras[i] = 0;
    end
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    go(ACT, 2'h0, 1'b0, 2'h0);
    nops(1);
    go(WR, 2'h0, 1'b1, 2'h0);
    go(ACT, 2'h1, 1'b0, 2'h0);
    go(NOP, 2'h0, 1'b0, 2'h2);
    nops(1);
    go(WR, 2'h1, 1'b0, 2'h0);
    go(NOP, 2'h1, 1'b0, 2'h2);
    nops(3);
    $display("test write auto precharge done");
    go(RD, 2'h1, 1'b1, 2'h0);
    go(NOP, 2'h1, 1'b0, 2'h1);
    nops(3);
    $display("test read auto precharge done");
    go(RD, 2'h3, 1'b0, 2'h0);
    go(PRE, 2'h3, 1'b0, 2'h0);
    go(ACT, 2'h2, 1'b0, 2'h0);
    go(REF, 2'h0, 1'b0, 2'h0);
    nops(2);
    go(PRE, 2'h0, 1'b1, 2'h0);
    nops(2);
    $display("test refusals done");
    go(ACT, 2'h3, 1'b0, 2'h0);
    go(RD, 2'h3, 1'b1, 2'h0);
    go(NOP, 2'h3, 1'b0, 2'h1);
    nops(4);
    $display("test row lock-out done");
    repeat (2)
    begin
      r = $random(seed);
      go(REF, r[1:0], r[2], 2'h0);
      go(ACT, r[4:3], 1'b0, 2'h0);
      nops(int'(RFC_CYC));
    end
    repeat (20)
    begin
      r = $random(seed);
      go(r[0] ? ACT : PRE, r[2:1], r[3], 2'h0);
    end
    nops(3);
    $display("test refresh and random done");
    close_out();
  end
endmodule
`default_nettype wire

//--- include/bapr_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bapr_bank_if;
  import bapr_pkg::*;
  logic        act;
  logic        rd;
  logic        wr;
  logic        ap;
  logic        pre;
  logic        rd_done;
  logic        wr_done;
  bapr_phase_t phase;
  logic        pre_start;
  logic        row_time_met;

  modport ctl (
    output act, rd, wr, ap, pre, rd_done, wr_done,
    input  phase, pre_start, row_time_met
  );
  modport bank (
    input  act, rd, wr, ap, pre, rd_done, wr_done,
    output phase, pre_start, row_time_met
  );
endinterface
`default_nettype wire

//--- include/bapr_pkg.sv
`default_nettype none
package bapr_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int CNT_W = 4;
  localparam int CLK_PERIOD_NS = 20;
  // plain defaults, no characterised figures available
  localparam int MIN_ROW_ACTIVE_NS = 40;
  localparam int ROW_PRECHARGE_NS = 20;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int REFRESH_CYCLE_NS = 80;

  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    return (ns <= CLK_PERIOD_NS) ? 1 : (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam logic [CNT_W-1:0] RAS_CYC = CNT_W'(cyc_up(MIN_ROW_ACTIVE_NS));
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(cyc_up(ROW_PRECHARGE_NS));
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(cyc_up(WRITE_RECOVERY_NS));
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(cyc_up(REFRESH_CYCLE_NS));
  localparam logic [CNT_W-1:0] CNT_DONE = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [ROW_W-1:0] ROW_ONE = 13'h0001;

  // phase seen by the rest of the device
  typedef enum logic [1:0] {PH_IDLE, PH_ROW_OPEN, PH_ACCESS, PH_PRECHARGE}
    bapr_phase_t;
  typedef enum logic [2:0] {BS_IDLE, BS_OPEN, BS_ACCESS, BS_RECOVER,
    BS_LOCKOUT, BS_PRECH} bapr_bank_st_t;

  typedef struct packed {
    bapr_bank_st_t    st;
    logic             is_wr;
    logic [CNT_W-1:0] ras_cnt;
    logic [CNT_W-1:0] cnt;
    logic             pre_start;
  } bapr_bank_reg_t;

  typedef struct packed {
    logic [CNT_W-1:0] ref_cnt;
    logic [ROW_W-1:0] next_row;
    logic [ROW_W-1:0] row;
    logic             fire;
  } bapr_top_reg_t;
endpackage
`default_nettype wire

//--- rtl/bank_autoprecharge_refresh.sv
//
// Summary of operation
// - address line with read or write selects auto precharge
// - auto precharge closes the addressed bank after its burst
// - auto precharge choice applies to one command only
// - precharge starts at earliest legal point, never before row-active time
// - read: precharge starts where earliest explicit precharge could go
// - write: precharge starts when write recovery ends
// - early single access waits internally for row-active time
// - other banks take commands during auto precharge, no data interruption
// - during precharge period other banks take all four commands
// - refresh row comes from an internal counter, address ignored
// - refresh period runs refresh cycle time from command registration
// - scope line low: one bank by bank selects; high: all banks
// - precharge to an idle or precharging bank does nothing
//
`timescale 1ns/1ps
`default_nettype none
module bank_autoprecharge_refresh
  import bapr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   cmd_activate,
  input  wire logic                   cmd_read,
  input  wire logic                   cmd_write,
  input  wire logic                   cmd_precharge,
  input  wire logic                   cmd_refresh,
  input  wire logic                   bank_select_low,
  input  wire logic                   bank_select_high,
  input  wire logic                   precharge_scope_line,
  input  wire logic                   burst_rd_done,
  input  wire logic                   burst_wr_done,
  input  wire logic [BANK_W-1:0]      burst_bank,
  output logic                        cmd_accept,
  output logic [2*NUM_BANKS-1:0]      bank_phase,
  output logic [NUM_BANKS-1:0]        precharge_start,
  output logic [NUM_BANKS-1:0]        row_time_met,
  output logic                        refresh_busy,
  output logic                        refresh_fire,
  output logic [ROW_W-1:0]            refresh_row
);
  localparam int RFC_DLY = int'(RFC_CYC);

  bapr_top_reg_t          cur;
  bapr_top_reg_t          next_cur;
  logic [BANK_W-1:0]      bank_idx;
  logic                   go;
  logic                   ref_go;
  logic                   all_idle;
  logic [NUM_BANKS-1:0]   idle_bits;
  logic [NUM_BANKS-1:0]   pre_hit;
  bapr_phase_t            ph [NUM_BANKS];
  bapr_phase_t            tgt_phase;

  bapr_bank_if bif [NUM_BANKS] ();

  // bank selects are taken apart from the scope line
  assign bank_idx = {bank_select_high, bank_select_low};

  // no activate, read, write or precharge reaches the banks while a refresh is running
  assign go = !refresh_busy;
  assign all_idle = &idle_bits;
  assign ref_go = cmd_refresh && go && all_idle;

  // two timers per bank, row-active and cnt, each bank runs on its own
  for (genvar i = 0; i < NUM_BANKS; i++)
  begin : g_bank
    localparam logic [BANK_W-1:0] IDX = BANK_W'(i);
    logic hit;

    assign hit = (bank_idx == IDX);

    // commands steer only the addressed bank
    assign bif[i].act = go && cmd_activate && hit;
    assign bif[i].rd = go && cmd_read && hit;
    assign bif[i].wr = go && cmd_write && hit;
    // the scope line only means auto precharge on a column access
    assign bif[i].ap = precharge_scope_line;
    // scope high reaches every bank, selects ignored
    assign bif[i].pre = go && cmd_precharge
      && (precharge_scope_line || hit);
    // burst end comes from the data path, tagged with its bank
    assign bif[i].rd_done = burst_rd_done && (burst_bank == IDX);
    assign bif[i].wr_done = burst_wr_done && (burst_bank == IDX);

    assign ph[i] = bif[i].phase;
    assign bank_phase[2*i +: 2] = bif[i].phase;
    assign precharge_start[i] = bif[i].pre_start;
    assign row_time_met[i] = bif[i].row_time_met;
    assign idle_bits[i] = (bif[i].phase == PH_IDLE);
    assign pre_hit[i] = bif[i].pre && (bif[i].phase == PH_ROW_OPEN);

    bapr_bank u_bank (
      .clk  (clk),
      .nrst (nrst),
      .bus  (bif[i])
    );

    sequence s_rd_ap;
      bif[i].rd && bif[i].ap && ph[i] == PH_ROW_OPEN;
    endsequence
    sequence s_rd_plain;
      bif[i].rd && !bif[i].ap && ph[i] == PH_ROW_OPEN;
    endsequence

    a_ap_taken: assert property (@(posedge clk) disable iff (!nrst)
      s_rd_ap |=> ph[i] == PH_ACCESS)
      else $error("read with auto precharge not tracked");
    a_ap_one_shot: assert property (@(posedge clk) disable iff (!nrst)
      s_rd_plain |=> ph[i] == PH_ROW_OPEN ##1 (ph[i] != PH_ACCESS
        || $past(bif[i].ap && (bif[i].rd || bif[i].wr))))
      else $error("auto precharge applied to a plain read");
    a_pre_all: assert property (@(posedge clk) disable iff (!nrst)
      cmd_precharge && precharge_scope_line && go
        && ph[i] == PH_ROW_OPEN |=> ph[i] == PH_PRECHARGE)
      else $error("precharge all missed an open bank");
  end

  // answer for the command decoder: did the command take effect
  always_comb
  begin
    tgt_phase = ph[bank_idx];
    cmd_accept = 1'b0;
    if (go)
    begin
      if (cmd_activate)
        cmd_accept = (tgt_phase == PH_IDLE);
      else if (cmd_read || cmd_write)
        cmd_accept = (tgt_phase == PH_ROW_OPEN);
      else if (cmd_precharge)
        cmd_accept = |pre_hit;
      else if (cmd_refresh)
        cmd_accept = all_idle;
    end
  end

  // refresh: one row per command, no auto-repeat
  always_comb
  begin
    next_cur = cur;
    next_cur.fire = ref_go;
    if (ref_go)
    begin
      // period counted from registration
      next_cur.ref_cnt = RFC_CYC;
      // internal row address, no address pins read
      next_cur.row = cur.next_row;
      next_cur.next_row = cur.next_row + ROW_ONE;
    end
    else if (refresh_busy)
      next_cur.ref_cnt = cur.ref_cnt - CNT_ONE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // refresh status straight from flops
  assign refresh_busy = (cur.ref_cnt != CNT_DONE);
  assign refresh_fire = cur.fire;
  assign refresh_row = cur.row;

  sequence s_ref_go;
    cmd_refresh && go && all_idle;
  endsequence

  a_ref_period: assert property (@(posedge clk) disable iff (!nrst)
    s_ref_go |=> refresh_busy ##RFC_DLY !refresh_busy)
    else $error("refresh period length wrong");
  a_ref_row: assert property (@(posedge clk) disable iff (!nrst)
    refresh_fire |-> cur.next_row == refresh_row + ROW_ONE)
    else $error("refresh row counter did not advance");
  a_ref_blocks: assert property (@(posedge clk) disable iff (!nrst)
    refresh_busy |-> !cmd_accept && $stable(bank_phase))
    else $error("command acted during refresh");
endmodule
`default_nettype wire

//--- rtl/bapr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module bapr_bank
  import bapr_pkg::*;
(
  input wire logic  clk,
  input wire logic  nrst,
  bapr_bank_if.bank bus
);
  // recovery starts the cycle after the done pulse, so the precharge
  // pulse lands exactly write-recovery cycles after that
  localparam int WR_DLY = int'(WR_CYC);
  localparam int RP_DLY = int'(RP_CYC);

  bapr_bank_reg_t cur;
  bapr_bank_reg_t next_cur;
  logic           ras_done;
  logic           burst_end;

  assign ras_done = (cur.ras_cnt == CNT_DONE);
  assign bus.row_time_met = ras_done;
  assign bus.pre_start = cur.pre_start;

  // per-bank sequencer, row-active timer runs free once loaded
  always_comb
  begin
    next_cur = cur;
    next_cur.pre_start = 1'b0;
    burst_end = 1'b0;
    if (!ras_done)
      next_cur.ras_cnt = cur.ras_cnt - CNT_ONE;
    unique case (cur.st)
      BS_IDLE:
        if (bus.act)
        begin
          next_cur.st = BS_OPEN;
          next_cur.ras_cnt = RAS_CYC;
        end
      BS_OPEN:
        if (bus.pre)
        begin
          next_cur.st = BS_PRECH;
          next_cur.cnt = RP_CYC;
        end
        else if ((bus.rd || bus.wr) && bus.ap)
        begin
          next_cur.st = BS_ACCESS;
          next_cur.is_wr = bus.wr;
        end
      BS_ACCESS:
        if (!cur.is_wr && bus.rd_done)
          burst_end = 1'b1;
        else if (cur.is_wr && bus.wr_done)
        begin
          next_cur.st = BS_RECOVER;
          next_cur.cnt = WR_CYC;
        end
      BS_RECOVER:
        if (cur.cnt == CNT_ONE)
          burst_end = 1'b1;
        else
          next_cur.cnt = cur.cnt - CNT_ONE;
      BS_LOCKOUT:
        burst_end = ras_done;
      BS_PRECH: // a precharge here is a no-op
        if (cur.cnt == CNT_ONE)
          next_cur.st = BS_IDLE;
        else
          next_cur.cnt = cur.cnt - CNT_ONE;
      default:
        next_cur.st = BS_IDLE;
    endcase
    // never start precharge ahead of the row-active time
    if (burst_end)
    begin
      if (ras_done)
      begin
        next_cur.st = BS_PRECH;
        next_cur.cnt = RP_CYC;
        next_cur.pre_start = 1'b1;
      end
      else
        next_cur.st = BS_LOCKOUT;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // coarse phase for the other blocks
  always_comb
  begin
    unique case (cur.st)
      BS_OPEN:                          bus.phase = PH_ROW_OPEN;
      BS_ACCESS, BS_RECOVER, BS_LOCKOUT: bus.phase = PH_ACCESS;
      BS_PRECH:                         bus.phase = PH_PRECHARGE;
      default:                          bus.phase = PH_IDLE;
    endcase
  end

  sequence s_rd_end;
    cur.st == BS_ACCESS && !cur.is_wr && bus.rd_done && ras_done;
  endsequence
  sequence s_wr_end;
    cur.st == BS_ACCESS && cur.is_wr && bus.wr_done && ras_done;
  endsequence

  a_ap_after_ras: assert property (@(posedge clk) disable iff (!nrst)
    bus.pre_start |-> $past(cur.ras_cnt) == CNT_DONE)
    else $error("auto precharge began before row-active time");
  a_rd_ap_start: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_end |=> bus.pre_start)
    else $error("read auto precharge not started at burst end");
  a_wr_recovery: assert property (@(posedge clk) disable iff (!nrst)
    s_wr_end |=> !bus.pre_start ##WR_DLY bus.pre_start)
    else $error("write auto precharge not timed by write recovery");
  a_prech_length: assert property (@(posedge clk) disable iff (!nrst)
    bus.pre_start |-> ##RP_DLY cur.st == BS_IDLE)
    else $error("precharge period length wrong");
  a_pre_idle_noop: assert property (@(posedge clk) disable iff (!nrst)
    bus.pre && !bus.act && cur.st == BS_IDLE |=> cur.st == BS_IDLE)
    else $error("precharge to idle bank changed state");
endmodule
`default_nettype wire
